//--- src/pmic_standby_pkg.sv
// Shared constants for the standby sequencer and its host-side driver.
// Assumes one clock at 40 MHz and a synchronous active-high reset.
package pmic_standby_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] RegWakeCfg   = 8'h34;
  localparam logic [7:0] RegWakeMask  = 8'h4f;
  localparam logic [7:0] RegWakeIrq   = 8'h64;
  localparam logic [7:0] RegEnableIrq = 8'h65;
  localparam logic [7:0] RegSleepMask = 8'h7d;
  localparam logic [7:0] RegTrigger   = 8'h85;
  localparam logic [7:0] RegSleepReq  = 8'h86;
  localparam logic [7:0] RegRtcCtrl   = 8'hc3;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int WakeIrqBit     = 3;
  localparam int EnableIrqBit   = 1;
  localparam int LpSelBit       = 3;
  localparam int TrigZeroBit    = 0;
  localparam int SleepOneBit    = 0;
  localparam int SleepTwoBit    = 1;
  localparam int StartDestLo    = 5;
  localparam int WakeMaskBit    = 3;
  localparam int WakeCfgHi      = 7;
  localparam int WakeCfgLo      = 6;
  localparam logic [1:0] DestActive  = 2'h3;
  localparam logic [1:0] WakeToActive = 2'h3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RstWakeMask  = 8'h08;
  localparam logic [7:0] RstEnableIrq = 8'h02;
  localparam logic [7:0] RstOther     = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam longint ClkHz          = 40000000;
  localparam longint WdWindowMin    = 13;
  localparam longint WdWindowCycles = WdWindowMin * 60 * ClkHz;
  localparam longint RailDelayUs    = 500;
  localparam longint RailDelayCycles = (RailDelayUs * ClkHz + 999999) / 1000000;
  localparam int     RstOutCycles   = 16;

  // ----------------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    StOff, StActiveSeq, StActive, StStandbySeq, StStandby, StLowPowerStandby
  } power_state_t;

endpackage

//--- src/pmic_reg_if.sv
// Register write channel between host driver and power device.
// Assumes both ends share clk; one write is taken per cycle of wrValid and wrReady.
interface pmic_reg_if;
  logic       wrValid;
  logic       wrReady;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic [7:0] wrMask;
  logic [7:0] rdAddr;
  logic [7:0] rdData;

  modport device (input wrValid, wrAddr, wrData, wrMask, rdAddr, output wrReady, rdData);
  modport host   (output wrValid, wrAddr, wrData, wrMask, rdAddr, input wrReady, rdData);
endinterface

//--- src/pmic_standby_device.sv
// Power device end: register file, state sequencer, watchdog and pin strap.
// Assumes the wake and strap pins are asynchronous; host writes arrive on clk.
module pmic_standby_device #(
  parameter longint WdCycles   = pmic_standby_pkg::WdWindowCycles,
  parameter longint DelayCycles = pmic_standby_pkg::RailDelayCycles
) (
  input  wire logic          clk,
  input  wire logic          srst,
  pmic_reg_if.device         bus,
  input  wire logic          wakePin,
  input  wire logic          wdDisableIn,
  output logic               wdDisableOut,
  output logic               wdDisableOe,
  output logic               resetOutLow,
  output logic               switcherFiveEn,
  output logic               linearThreeEn,
  output logic               watchdogExpired,
  output pmic_standby_pkg::power_state_t powerState
);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [7:0] regs_r [0:255];
  logic       wakeS1_r, wakeS2_r, wakePrev_r;
  logic       strapS1_r, strapS2_r, strapDone_r, wdPowerHold_r;
  logic       wakeFall, trigZero, gateOpen, wakeIrqSet;
  // Full window needs 35 bits at 40 MHz; 32 would wrap the default
  logic [35:0] wdCnt_r;
  logic [31:0] seqCnt_r;
  pmic_standby_pkg::power_state_t state_r;
  logic       fromLowPower_r;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] dat,
                                       input logic [7:0] msk);
    merge = (old & msk) | (dat & ~msk);
  endfunction

  assign bus.wrReady = 1'b1;
  assign bus.rdData  = regs_r[bus.rdAddr];

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    wakeS1_r   <= wakePin;
    wakeS2_r   <= wakeS1_r;
    wakePrev_r <= srst ? 1'b1 : wakeS2_r;
    strapS1_r  <= wdDisableIn;
    strapS2_r  <= strapS1_r;
  end

  // Only a high-to-low change counts; a pin already low never wakes
  assign wakeFall = wakePrev_r & ~wakeS2_r;
  assign wakeIrqSet = wakeFall && !regs_r[pmic_standby_pkg::RegWakeMask][pmic_standby_pkg::WakeMaskBit];
  assign trigZero = bus.wrValid && bus.wrAddr == pmic_standby_pkg::RegTrigger
                    && !bus.wrMask[pmic_standby_pkg::TrigZeroBit]
                    && bus.wrData[pmic_standby_pkg::TrigZeroBit];

  // Enable flag blocks every lower trigger; wake flag gates after ordinary standby
  assign gateOpen = !regs_r[pmic_standby_pkg::RegEnableIrq][pmic_standby_pkg::EnableIrqBit]
                    && (fromLowPower_r
                        || !regs_r[pmic_standby_pkg::RegWakeIrq][pmic_standby_pkg::WakeIrqBit]);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 256; i++)
        regs_r[i] <= pmic_standby_pkg::RstOther;
      regs_r[pmic_standby_pkg::RegWakeMask]  <= pmic_standby_pkg::RstWakeMask;
      regs_r[pmic_standby_pkg::RegEnableIrq] <= pmic_standby_pkg::RstEnableIrq;
    end
    else
    begin
      if (bus.wrValid)
      begin
        // Interrupt registers are write-one-to-clear
        if (bus.wrAddr == pmic_standby_pkg::RegWakeIrq || bus.wrAddr == pmic_standby_pkg::RegEnableIrq)
          regs_r[bus.wrAddr] <= regs_r[bus.wrAddr] & ~(bus.wrData & ~bus.wrMask);
        else if (bus.wrAddr != pmic_standby_pkg::RegTrigger)
          regs_r[bus.wrAddr] <= merge(regs_r[bus.wrAddr], bus.wrData, bus.wrMask);
      end
      // A set in the same cycle as a clear wins
      if (wakeIrqSet)
        regs_r[pmic_standby_pkg::RegWakeIrq][pmic_standby_pkg::WakeIrqBit] <= 1'b1;
      if (state_r == pmic_standby_pkg::StLowPowerStandby && wakeFall)
        regs_r[pmic_standby_pkg::RegEnableIrq][pmic_standby_pkg::EnableIrqBit] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // State sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r        <= pmic_standby_pkg::StOff;
      seqCnt_r       <= 32'h0;
      fromLowPower_r <= 1'b0;
      switcherFiveEn <= 1'b0;
      linearThreeEn  <= 1'b0;
    end
    else
    begin
      case (state_r)
        pmic_standby_pkg::StOff:
        begin
          state_r <= pmic_standby_pkg::StActiveSeq;
          seqCnt_r <= 32'h0;
        end
        pmic_standby_pkg::StActiveSeq:
        begin
          // Switcher five first; linear three follows once seqCnt_r reaches DelayCycles
          switcherFiveEn <= 1'b1;
          seqCnt_r <= seqCnt_r + 32'h1;
          if (seqCnt_r >= DelayCycles[31:0])
          begin
            linearThreeEn <= 1'b1;
            state_r <= pmic_standby_pkg::StActive;
          end
        end
        pmic_standby_pkg::StActive:
          // Same trigger and sequence for both standby kinds
          if (trigZero && gateOpen)
          begin
            state_r <= pmic_standby_pkg::StStandbySeq;
            seqCnt_r <= 32'h0;
          end
        pmic_standby_pkg::StStandbySeq:
        begin
          linearThreeEn  <= 1'b0;
          switcherFiveEn <= 1'b0;
          // Select bit only picks the resulting state
          state_r <= regs_r[pmic_standby_pkg::RegRtcCtrl][pmic_standby_pkg::LpSelBit]
                     ? pmic_standby_pkg::StLowPowerStandby : pmic_standby_pkg::StStandby;
        end
        pmic_standby_pkg::StStandby, pmic_standby_pkg::StLowPowerStandby:
          if (wakeIrqSet || (state_r == pmic_standby_pkg::StLowPowerStandby && wakeFall))
          begin
            fromLowPower_r <= state_r == pmic_standby_pkg::StLowPowerStandby;
            state_r <= pmic_standby_pkg::StActiveSeq;
            seqCnt_r <= 32'h0;
          end
        default: state_r <= pmic_standby_pkg::StOff;
      endcase
    end
  end
  assign powerState = state_r;
  // Sleep request bits are only stored; no sleep transition is modelled here

  // ----------------------------------------------------------------------
  // Watchdog and strap
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      strapDone_r   <= 1'b0;
      wdPowerHold_r <= 1'b0;
      wdDisableOe   <= 1'b0;
      wdDisableOut  <= 1'b0;
    end
    else if (!strapDone_r)
    begin
      wdPowerHold_r <= strapS2_r;
      wdDisableOut  <= strapS2_r;
      strapDone_r   <= 1'b1;
      wdDisableOe   <= 1'b1;
    end
    else
      wdDisableOut <= wdPowerHold_r;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wdCnt_r         <= 36'h0;
      watchdogExpired <= 1'b0;
      resetOutLow     <= 1'b0;
    end
    else
    begin
      resetOutLow <= state_r == pmic_standby_pkg::StActive;
      // Enabled by default; host service is any write while active
      if (!resetOutLow || bus.wrValid || wdPowerHold_r)
        wdCnt_r <= 36'h0;
      else if (wdCnt_r >= WdCycles[35:0] - 36'h1)
        watchdogExpired <= 1'b1;
      else
        wdCnt_r <= wdCnt_r + 36'h1;
    end
  end

endmodule

//--- src/pmic_standby_host.sv
// Host end: issues the low-power standby entry and exit write sequences.
// Assumes the device takes one write per cycle while wrReady is high.
module pmic_standby_host (
  input  wire logic  clk,
  input  wire logic  srst,
  pmic_reg_if.host   bus,
  input  wire logic  enterReq,
  input  wire logic  wokeActive,
  output logic       busy,
  output logic       done
);

  // ----------------------------------------------------------------------
  // Write script
  // ----------------------------------------------------------------------
  localparam int Steps = 13;
  localparam int EntryLast = 6;
  logic [3:0] step_r;
  logic       run_r, waitWake_r;

  function automatic logic [23:0] script(input logic [3:0] s);
    case (s)
      4'h0: script = {pmic_standby_pkg::RegRtcCtrl,   8'h08, 8'hf7};
      4'h1: script = {pmic_standby_pkg::RegSleepMask, 8'hc0, 8'h3f};
      4'h2: script = {pmic_standby_pkg::RegWakeCfg,   8'hc0, 8'h3f};
      4'h3: script = {pmic_standby_pkg::RegRtcCtrl,   8'h60, 8'h9f};
      4'h4: script = {pmic_standby_pkg::RegWakeIrq,   8'h08, 8'hf7};
      4'h5: script = {pmic_standby_pkg::RegWakeMask,  8'h00, 8'hf7};
      4'h6: script = {pmic_standby_pkg::RegTrigger,   8'h01, 8'hfe};
      4'h7: script = {pmic_standby_pkg::RegSleepMask, 8'h00, 8'h3f};
      4'h8: script = {pmic_standby_pkg::RegSleepReq,  8'h03, 8'hfc};
      4'h9: script = {pmic_standby_pkg::RegWakeIrq,   8'h08, 8'hf7};
      4'ha: script = {pmic_standby_pkg::RegEnableIrq, 8'h02, 8'hfd};
      default: script = 24'h0;
    endcase
  endfunction

  assign bus.wrValid = run_r;
  assign {bus.wrAddr, bus.wrData, bus.wrMask} = script(step_r);
  assign bus.rdAddr = pmic_standby_pkg::RegEnableIrq;
  assign busy = run_r | waitWake_r;

  // ----------------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      step_r     <= 4'h0;
      run_r      <= 1'b0;
      waitWake_r <= 1'b0;
      done       <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!run_r && !waitWake_r && enterReq)
      begin
        step_r <= 4'h0;
        run_r  <= 1'b1;
      end
      else if (waitWake_r && wokeActive)
      begin
        waitWake_r <= 1'b0;
        run_r      <= 1'b1;
        step_r     <= 4'h7;
      end
      else if (run_r && bus.wrReady)
      begin
        if (step_r == 4'(EntryLast))
        begin
          run_r      <= 1'b0;
          waitWake_r <= 1'b1;
        end
        else if (step_r == 4'(Steps - 3))
        begin
          run_r <= 1'b0;
          done  <= 1'b1;
        end
        else
          step_r <= step_r + 4'h1;
      end
    end
  end

endmodule

//--- sim/pmic_standby_monitor.sv
// Checker on the host-to-device channel and the first device's sequencer pins.
// Assumes it sits beside the interface in the bench top; one clock domain.
module pmic_standby_monitor #(
  parameter int DelayCyc = 10
) (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       wrValid,
  input wire logic       wrReady,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] wrMask,
  input wire logic       switcherFiveEn,
  input wire logic       linearThreeEn,
  input wire logic       resetOutLow,
  input wire pmic_standby_pkg::power_state_t powerState
);
  // ------------------------------------------------------------
  // Helper count
  // ------------------------------------------------------------
  // Slack of one cycle below and eight above: the delay is only fixed as a minimum
  localparam int DelayLo = DelayCyc - 1;
  localparam int DelayHi = DelayCyc + 8;
  int s5Cnt;
  always_ff @(posedge clk)
  begin
    if (srst || !switcherFiveEn)
      s5Cnt <= 0;
    else if (s5Cnt < 1000)
      s5Cnt <= s5Cnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  ready_high_a: assert property (wrReady)
    else $error("write channel not ready");
  rail_order_a: assert property (linearThreeEn |-> switcherFiveEn)
    else $error("linear rail on without switcher five");
  trig_order_a: assert property (wrValid && wrAddr == pmic_standby_pkg::RegTrigger |->
    $past(wrValid) && $past(wrAddr) == pmic_standby_pkg::RegWakeMask)
    else $error("trigger not preceded by wake unmask");
  trig_value_a: assert property (wrValid && wrAddr == pmic_standby_pkg::RegTrigger |->
    wrData[0] && !wrMask[0]) else $error("trigger write value wrong");
  select_value_a: assert property (wrValid && wrAddr == pmic_standby_pkg::RegRtcCtrl |->
    {wrData, wrMask} == 16'h08f7 || {wrData, wrMask} == 16'h609f)
    else $error("select or destination write wrong");
  exit_order_a: assert property (wrValid && wrAddr == pmic_standby_pkg::RegEnableIrq |->
    $past(wrAddr) == pmic_standby_pkg::RegWakeIrq
    && $past(wrAddr, 2) == pmic_standby_pkg::RegSleepReq) else $error("exit order wrong");
  entry_source_a: assert property (powerState == pmic_standby_pkg::StStandbySeq
    && $past(powerState) != pmic_standby_pkg::StStandbySeq
    |-> $past(powerState) == pmic_standby_pkg::StActive) else $error("entry not from active");
  entry_result_a: assert property ($past(powerState) == pmic_standby_pkg::StStandbySeq
    && powerState != pmic_standby_pkg::StStandbySeq |-> powerState inside
    {pmic_standby_pkg::StStandby, pmic_standby_pkg::StLowPowerStandby})
    else $error("entry sequence ended in wrong state");
  lp_exit_a: assert property ($past(powerState) == pmic_standby_pkg::StLowPowerStandby
    && powerState != pmic_standby_pkg::StLowPowerStandby
    |-> powerState == pmic_standby_pkg::StActiveSeq) else $error("bad exit from standby");
  rail_gap_a: assert property ($rose(linearThreeEn) |-> s5Cnt >= DelayLo)
    else $error("linear rail too early");
  rail_bound_a: assert property ($rose(switcherFiveEn) |-> ##[1:DelayHi] linearThreeEn)
    else $error("linear rail too late");
  reset_out_a: assert property (resetOutLow |-> powerState == pmic_standby_pkg::StActive
    || $past(powerState) == pmic_standby_pkg::StActive) else $error("reset released off active");
  lp_seen_c: cover property (powerState == pmic_standby_pkg::StLowPowerStandby);
  trig_seen_c: cover property (wrValid && wrAddr == pmic_standby_pkg::RegTrigger);
  rail_seen_c: cover property ($rose(linearThreeEn));
endmodule

//--- sim/test_pmic_lowpower_standby_exit.sv
// Bench: host and device joined on one channel, a second device driven by tasks.
// Assumes reduced watchdog and rail delay counts; inputs change on falling edges.
module test_pmic_lowpower_standby_exit;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint Wd = 3000;
  localparam longint Dly = 10;
  logic clk, srst, enterReq, wokeActive, busy, done, wake1, wake2, strap1, strap2;
  logic wdOut1, wdOe1, wdOut2, wdOe2, rst1, rst2, s51, s52, l31, l32, exp1, exp2;
  wire logic pin1 = wdOe1 ? wdOut1 : strap1;
  wire logic pin2 = wdOe2 ? wdOut2 : strap2;
  pmic_standby_pkg::power_state_t ps1, ps2;
  int fail_count, cmp_count;
  logic [23:0] trace[$];
  logic [23:0] script[11] = '{24'hc308f7, 24'h7dc03f, 24'h34c03f, 24'hc3609f, 24'h6408f7,
    24'h4f00f7, 24'h8501fe, 24'h7d003f, 24'h8603fc, 24'h6408f7, 24'h6502fd};
  pmic_reg_if bus1();
  pmic_reg_if bus2();
  pmic_standby_host u_pmic_standby_host (.clk(clk), .srst(srst), .bus(bus1),
    .enterReq(enterReq), .wokeActive(wokeActive), .busy(busy), .done(done));
  pmic_standby_device #(.WdCycles(Wd), .DelayCycles(Dly)) u_pmic_standby_device (.clk(clk),
    .srst(srst), .bus(bus1), .wakePin(wake1), .wdDisableIn(pin1), .wdDisableOut(wdOut1),
    .wdDisableOe(wdOe1), .resetOutLow(rst1), .switcherFiveEn(s51), .linearThreeEn(l31),
    .watchdogExpired(exp1), .powerState(ps1));
  pmic_standby_device #(.WdCycles(Wd), .DelayCycles(Dly)) u_pmic_standby_device_b (.clk(clk),
    .srst(srst), .bus(bus2), .wakePin(wake2), .wdDisableIn(pin2), .wdDisableOut(wdOut2),
    .wdDisableOe(wdOe2), .resetOutLow(rst2), .switcherFiveEn(s52), .linearThreeEn(l32),
    .watchdogExpired(exp2), .powerState(ps2));
  pmic_standby_monitor #(.DelayCyc(Dly)) u_pmic_standby_monitor (.clk(clk), .srst(srst),
    .wrValid(bus1.wrValid), .wrReady(bus1.wrReady), .wrAddr(bus1.wrAddr),
    .wrData(bus1.wrData), .wrMask(bus1.wrMask), .switcherFiveEn(s51),
    .linearThreeEn(l31), .resetOutLow(rst1), .powerState(ps1));
  always @(posedge clk)
    if (bus1.wrValid === 1'b1 && !srst)
      trace.push_back({bus1.wrAddr, bus1.wrData, bus1.wrMask});
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(negedge clk);
    bus2.wrValid = 1'b1;
    bus2.wrAddr = a;
    bus2.wrData = d;
    bus2.wrMask = m;
    @(negedge clk);
    bus2.wrValid = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    bus2.rdAddr = a;
    @(negedge clk);
    chk("register", {16'h0, e}, {16'h0, bus2.rdData});
  endtask
  // Polls for a state, or with hold set waits 30 cycles and then checks it once
  task automatic stq(input bit d, input pmic_standby_pkg::power_state_t s, input bit hold);
    for (int i = 0; i < 300 && (hold || (d ? ps2 : ps1) !== s); i++)
      if (!hold || i < 30)
        @(negedge clk);
    chk("state", {21'h0, s}, {21'h0, d ? ps2 : ps1});
  endtask
  task automatic hostRun(input bit refused);
    trace.delete();
    @(negedge clk);
    enterReq = 1'b1;
    @(negedge clk);
    enterReq = 1'b0;
    for (int i = 0; i < 100 && trace.size() < 7; i++)
      @(negedge clk);
    if (refused)
      stq(0, pmic_standby_pkg::StActive, 1);
    else
    begin
      stq(0, pmic_standby_pkg::StLowPowerStandby, 0);
      wake1 = 1'b0;
      stq(0, pmic_standby_pkg::StActive, 0);
    end
    chk("busy", 24'h1, {23'h0, busy});
    wokeActive = 1'b1;
    for (int i = 0; i < 100 && done !== 1'b1; i++)
      @(negedge clk);
    chk("done", 24'h1, {23'h0, done});
    chk("busy", 24'h0, {23'h0, busy});
    wokeActive = 1'b0;
    wake1 = 1'b1;
    for (int i = 0; i < 11; i++)
      chk("write", script[i], trace[i]);
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  initial
  begin
    {srst, enterReq, wokeActive, wake1, wake2, strap1, strap2} = 7'b1001110;
    {bus2.wrValid, bus2.wrAddr, bus2.wrData, bus2.wrMask, bus2.rdAddr} = 33'h0;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    stq(0, pmic_standby_pkg::StActive, 0);
    stq(1, pmic_standby_pkg::StActive, 0);
    chk("strap", 24'h00000e, {20'h0, wdOe1, wdOut1, wdOe2, wdOut2});
    hostRun(1'b1);
    hostRun(1'b0);
    rd(pmic_standby_pkg::RegWakeMask, 8'h08);
    rd(pmic_standby_pkg::RegEnableIrq, 8'h02);
    wr(pmic_standby_pkg::RegSleepMask, 8'hc0, 8'h3f);
    wr(pmic_standby_pkg::RegSleepReq, 8'h03, 8'hfc);
    wr(pmic_standby_pkg::RegTrigger, 8'h01, 8'hfe);
    stq(1, pmic_standby_pkg::StActive, 1);
    chk("rails", 24'h7, {21'h0, rst2, s52, l32});
    wr(pmic_standby_pkg::RegEnableIrq, 8'h02, 8'hfd);
    rd(pmic_standby_pkg::RegEnableIrq, 8'h00);
    wr(pmic_standby_pkg::RegWakeCfg, 8'h15, 8'h00);
    wr(pmic_standby_pkg::RegWakeCfg, 8'hc0, 8'h3f);
    rd(pmic_standby_pkg::RegWakeCfg, 8'hd5);
    wr(pmic_standby_pkg::RegWakeMask, 8'h00, 8'hf7);
    wr(pmic_standby_pkg::RegTrigger, 8'h01, 8'hfe);
    stq(1, pmic_standby_pkg::StStandby, 0);
    stq(1, pmic_standby_pkg::StStandby, 1);
    chk("rails", 24'h0, {21'h0, rst2, s52, l32});
    wake2 = 1'b0;
    stq(1, pmic_standby_pkg::StActive, 0);
    rd(pmic_standby_pkg::RegWakeIrq, 8'h08);
    wake2 = 1'b1;
    wr(pmic_standby_pkg::RegTrigger, 8'h01, 8'hfe);
    stq(1, pmic_standby_pkg::StActive, 1);
    wr(pmic_standby_pkg::RegWakeIrq, 8'h08, 8'hf7);
    rd(pmic_standby_pkg::RegWakeIrq, 8'h00);
    wr(pmic_standby_pkg::RegRtcCtrl, 8'h08, 8'hf7);
    wr(pmic_standby_pkg::RegRtcCtrl, 8'h60, 8'h9f);
    rd(pmic_standby_pkg::RegRtcCtrl, 8'h68);
    wr(pmic_standby_pkg::RegTrigger, 8'h01, 8'hfe);
    stq(1, pmic_standby_pkg::StLowPowerStandby, 0);
    wake2 = 1'b0;
    stq(1, pmic_standby_pkg::StActive, 0);
    rd(pmic_standby_pkg::RegEnableIrq, 8'h02);
    wr(pmic_standby_pkg::RegTrigger, 8'h01, 8'hfe);
    stq(1, pmic_standby_pkg::StActive, 1);
    chk("watchdog", 24'h0, {22'h0, exp1, exp2});
    repeat (Wd + 100) @(negedge clk);
    chk("watchdog", 24'h1, {22'h0, exp1, exp2});
    wrap_up();
  end
endmodule
